// ### dv/nvm_access_ctrl_properties.sv
// nvm_access_ctrl_properties: port timing checks for the access control.
// assumes a bind into nvm_access_ctrl; sees only its ports.
module nvm_access_ctrl_properties
    import nvm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic dev_reset,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [7:0] nv_rdata,
    input wire nvm_pkg::nvm_req_t nv_req,
    input wire logic irq
);
    logic [15:0] hold_cnt;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // length of the current write or erase request
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            hold_cnt <= 16'h0000;
        else if (nv_req.valid && nv_req.op != NVM_OP_READ)
            hold_cnt <= hold_cnt + 16'h0001;
        else
            hold_cnt <= 16'h0000;
    end

    sequence s_req;
        (read || write) && waitrequest;
    endsequence
    sequence s_prog;
        nv_req.valid && nv_req.op != NVM_OP_READ;
    endsequence
    sequence s_fetch;
        nv_req.valid && nv_req.op == NVM_OP_READ;
    endsequence

    a_ack_next: assert property (s_req |=> !waitrequest)
        else $error("no acknowledge after request");
    a_ack_single: assert property (!waitrequest |=> waitrequest)
        else $error("acknowledge longer than one cycle");
    a_fetch_pulse: assert property (s_fetch |=> !nv_req.valid)
        else $error("read request longer than one cycle");
    a_fetch_space: assert property (
        s_fetch |-> nv_req.space == NVM_SP_EEPROM)
        else $error("read request outside eeprom");
    a_write_block: assert property (
        nv_req.valid && nv_req.op == NVM_OP_WRITE
        && nv_req.space != NVM_SP_EEPROM |-> nv_req.addr[2:0] == 3'h0)
        else $error("program write not block aligned");
    a_erase_block: assert property (
        nv_req.valid && nv_req.op == NVM_OP_ERASE
        |-> nv_req.addr[5:0] == 6'h00)
        else $error("erase not row aligned");
    a_erase_space: assert property (
        nv_req.valid && nv_req.op == NVM_OP_ERASE
        |-> nv_req.space != NVM_SP_EEPROM)
        else $error("erase aimed at eeprom");
    // request also stands through the cycle in which done is raised
    a_prog_length: assert property (
        $fell(nv_req.valid) && !$past(dev_reset)
        && $past(nv_req.op) != NVM_OP_READ |-> hold_cnt == PROG_CYCLES + 1)
        else $error("self-timed cycle of wrong length");
    a_req_steady: assert property (
        s_prog ##1 nv_req.valid |-> $stable(nv_req))
        else $error("request changed during cycle");
    a_abort_drop: assert property (dev_reset |=> !nv_req.valid)
        else $error("request kept after device reset");
endmodule

bind nvm_access_ctrl nvm_access_ctrl_properties u_props
(
    .core_clk(core_clk), .rst(rst), .dev_reset(dev_reset),
    .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .nv_rdata(nv_rdata), .nv_req(nv_req), .irq(irq)
);

// ### dv/nvm_access_ctrl_test.sv
// nvm_access_ctrl_test: self-checking bench for the access control.
// assumes the bench plays both the bus master and the storage array.
module nvm_access_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import nvm_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, dev_reset = 1'b0;
    logic read = 1'b0, write = 1'b0, waitrequest, irq;
    logic [4:0] address = 5'h00;
    logic [3:0] byteenable = 4'h1;
    logic [31:0] writedata = 32'h0, readdata;
    logic [7:0] nv_rdata = 8'h5a;
    nvm_req_t nv_req;
    int fails = 0, samples_checked = 0, cycles = 0;

    nvm_access_ctrl dut (.core_clk(core_clk), .rst(rst),
        .dev_reset(dev_reset), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .nv_rdata(nv_rdata), .nv_req(nv_req), .irq(irq));

    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic complete_run();
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // holds the request until waitrequest is sampled low
    task automatic bus(input logic [4:0] a, input bit w,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= {24'h0, d};
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input string n, input logic [4:0] a,
        input logic [7:0] e);
        logic [7:0] q;
        bus(a, 1'b0, 8'h00, q);
        check(n, e, q);
    endtask

    task automatic wait_req(input int lim, output bit seen);
        seen = 0;
        repeat (lim)
        begin
            @(posedge core_clk);
            if (nv_req.valid === 1'b1)
            begin
                seen = 1;
                break;
            end
        end
    endtask

    task automatic t_regs();
        logic [4:0] offs[8] = '{OFF_PTR_LOW, OFF_PTR_HIGH, OFF_PTR_UPPER,
            OFF_LATCH, OFF_CTRL, OFF_IRQ_STATUS, OFF_IRQ_MASK, 5'h1c};
        foreach (offs[i])
            rd_chk("reset_value", offs[i], 8'h00);
        wr(OFF_PTR_LOW, 8'h2d);
        wr(OFF_PTR_HIGH, 8'hb7);
        wr(OFF_PTR_UPPER, 8'hff);
        wr(OFF_LATCH, 8'h11);
        wr(5'h1c, 8'hff);
        // low byte lane off: the write must be ignored
        byteenable <= 4'he;
        wr(OFF_LATCH, 8'h77);
        byteenable <= 4'h1;
        rd_chk("ptr_low", OFF_PTR_LOW, 8'h2d);
        rd_chk("ptr_high", OFF_PTR_HIGH, 8'hb7);
        rd_chk("ptr_upper", OFF_PTR_UPPER, 8'h3f);
        rd_chk("latch", OFF_LATCH, 8'h11);
        rd_chk("unmapped", 5'h1c, 8'h00);
        wr(OFF_CTRL, 8'h20);
        rd_chk("ctrl_unused", OFF_CTRL, 8'h00);
    endtask

    task automatic t_fetch();
        logic [7:0] sel[3] = '{8'h80, 8'h40, 8'hc0};
        bit seen;
        wr(OFF_PTR_UPPER, 8'h00);
        // storage answers while the read request stands
        nv_rdata <= 8'ha5;
        wr(OFF_CTRL, 8'h01);
        wait_req(4, seen);
        nv_rdata <= 8'h5a;
        check("fetch_req", 1, seen);
        check("fetch_op", NVM_OP_READ, nv_req.op);
        check("fetch_space", NVM_SP_EEPROM, nv_req.space);
        check("fetch_addr", 22'h00b72d, nv_req.addr);
        rd_chk("fetch_latch", OFF_LATCH, 8'ha5);
        rd_chk("fetch_ctrl", OFF_CTRL, 8'h00);
        foreach (sel[i])
        begin
            wr(OFF_CTRL, sel[i] | 8'h01);
            wait_req(4, seen);
            check("fetch_refused", 0, seen);
            rd_chk("refused_ctrl", OFF_CTRL, sel[i]);
        end
    endtask

    task automatic t_no_permit();
        bit seen;
        wr(OFF_CTRL, 8'h82);
        wait_req(4, seen);
        check("unpermitted", 0, seen);
        rd_chk("fault_ctrl", OFF_CTRL, 8'h88);
        wr(OFF_CTRL, 8'h00);
    endtask

    task automatic t_program();
        logic [7:0] c[4] = '{8'h06, 8'h86, 8'hd6, 8'h96};
        nvm_op_t op[4] = '{NVM_OP_WRITE, NVM_OP_WRITE, NVM_OP_ERASE,
            NVM_OP_ERASE};
        nvm_space_t sp[4] = '{NVM_SP_EEPROM, NVM_SP_FLASH, NVM_SP_CONFIG,
            NVM_SP_FLASH};
        logic [21:0] ad[4] = '{22'h25b72d, 22'h25b728, 22'h25b700,
            22'h25b700};
        logic [7:0] q;
        bit seen;
        wr(OFF_PTR_UPPER, 8'h25);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_CTRL, c[i]);
            wait_req(4, seen);
            check("prog_req", 1, seen);
            check("prog_op", op[i], nv_req.op);
            check("prog_space", sp[i], nv_req.space);
            check("prog_addr", ad[i], nv_req.addr);
            check("prog_data", 8'ha5, nv_req.data);
            // tries to drop launch and both selects mid-cycle
            wr(OFF_CTRL, c[i] & 8'h3d);
            rd_chk("prog_busy", OFF_CTRL, c[i]);
            q = 8'hff;
            for (int n = 0; n < 200 && q[1] !== 1'b0; n++)
                bus(OFF_CTRL, 1'b0, 8'h00, q);
            check("prog_done", c[i] & 8'hed, q);
        end
    endtask

    task automatic t_abort();
        bit seen;
        wr(OFF_CTRL, 8'h86);
        wait_req(4, seen);
        repeat (5) @(posedge core_clk);
        dev_reset <= 1'b1;
        @(posedge core_clk);
        dev_reset <= 1'b0;
        @(posedge core_clk);
        check("abort_valid", 0, nv_req.valid);
        rd_chk("abort_ctrl", OFF_CTRL, 8'h88);
    endtask

    task automatic t_irq();
        rd_chk("status", OFF_IRQ_STATUS, 8'h07);
        check("irq_masked", 0, irq);
        wr(OFF_IRQ_MASK, 8'h02);
        rd_chk("mask", OFF_IRQ_MASK, 8'h02);
        check("irq_set", 1, irq);
        wr(OFF_IRQ_STATUS, 8'h02);
        rd_chk("status_clr", OFF_IRQ_STATUS, 8'h05);
        check("irq_clr", 0, irq);
    endtask

    // ceiling well above the four 250-cycle programs
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            fails++;
            complete_run();
        end
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_fetch();
        t_no_permit();
        t_program();
        t_abort();
        t_irq();
        complete_run();
    end
endmodule

// ### hdl/nvm_access_ctrl.sv
// nvm_access_ctrl: table pointer, table latch and control register that
// steer reads, writes and erases of on-chip nonvolatile storage.
// assumes an Avalon-MM master on core_clk and a storage array that
// samples nv_req and presents read data while the read request stands.
// Operation
// - code select high targets program flash, low targets data EEPROM.
// - config select high targets configuration space, else decides.
// - row erase select makes next launch erase; cleared when erase ends.
// - without row erase select a launched cycle only writes.
// - premature end by reset or improper attempt sets fault flag.
// - permit bit low inhibits every write and erase cycle.
// - launch starts self-timed cycle; hardware clears it at completion.
// - software can only set launch; writing zero does nothing.
// - fetch starts one-cycle read, cleared by hardware, set-only.
// - fetch cannot be set while code or config select is high.
// - a fault leaves code and config select untouched.
// - unused control bit reads zero and ignores writes.
// - three pointer bytes form 22 bits; top bit picks config space (here the config select bit picks it; pointer bit 21 is only address).
// - table latch holds the data byte moved by table operations.
// - program write targets 8-byte block, low three bits ignored.
// - erase targets 64-byte block, low six bits ignored.
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
module nvm_access_ctrl
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic dev_reset,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [7:0] nv_rdata,
    output nvm_pkg::nvm_req_t nv_req,
    output logic irq
);
    import nvm_pkg::*;

    logic [PTR_W-1:0] ptr_reg;
    logic [7:0] latch_reg;
    logic code_sel_reg;
    logic cfg_sel_reg;
    logic erase_sel_reg;
    logic fault_reg;
    logic permit_reg;
    logic launch_reg;
    logic fetch_reg;
    logic [IRQ_W-1:0] status_reg;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] status_next;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    nvm_req_t req_reg;
    logic [7:0] ctrl_view;
    logic [7:0] wb;
    logic wr_acc;
    logic wr_ctrl;
    logic launch_req;
    logic start;
    logic improper;
    logic fetch_req;
    logic aborted;
    logic tmr_busy;
    logic tmr_done;
    logic [PTR_W-1:0] launch_addr;
    nvm_space_t launch_space;
    logic launch_erase;

    assign waitrequest = wait_reg;
    assign readdata = rdata_reg;
    assign irq = irq_reg;
    assign nv_req = req_reg;

    assign wb = writedata[7:0];
    // only the low byte lane carries register data
    assign wr_acc = write && !wait_reg && byteenable[0];
    assign wr_ctrl = wr_acc && (address == OFF_CTRL);

    assign ctrl_view = {code_sel_reg, cfg_sel_reg, 1'b0, erase_sel_reg,
                        fault_reg, permit_reg, launch_reg, fetch_reg};

    // only a one written while idle starts anything
    assign launch_req = wr_ctrl && wb[BIT_LAUNCH] && !launch_reg
                        && !fetch_reg;
    // permit written in the same access counts, as in the unlock sequence
    assign start = launch_req && wb[BIT_PERMIT];
    assign improper = launch_req && !wb[BIT_PERMIT];
    assign fetch_req = wr_ctrl && wb[BIT_FETCH] && !wb[BIT_CODE_SEL]
                       && !wb[BIT_CFG_SEL] && !launch_reg && !fetch_reg
                       && !wb[BIT_LAUNCH];
    // any device reset during a self-timed cycle cuts it short
    assign aborted = dev_reset && launch_reg;

    // target space and block address for a launched cycle
    always_comb
    begin
        if (wb[BIT_CFG_SEL])
            launch_space = NVM_SP_CONFIG;
        else if (wb[BIT_CODE_SEL])
            launch_space = NVM_SP_FLASH;
        else
            launch_space = NVM_SP_EEPROM;
        // eeprom has no row erase; it does erase/write in one cycle
        launch_erase = wb[BIT_ERASE_SEL]
                       && (launch_space != NVM_SP_EEPROM);
        launch_addr = ptr_reg;
        if (launch_erase)
            launch_addr[ERASE_BLK_LSB-1:0] = '0;
        else if (launch_space != NVM_SP_EEPROM)
            launch_addr[WRITE_BLK_LSB-1:0] = '0;
    end

    nvm_cycle_timer u_timer
    (
        .core_clk(core_clk),
        .rst(rst),
        .start(start && !dev_reset),
        .abort(dev_reset),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // bus handshake: one wait cycle, then a single-cycle answer
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wait_reg <= 1'b1;
        else if ((read || write) && wait_reg)
            wait_reg <= 1'b0;
        else
            wait_reg <= 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rdata_reg <= RDATA_RESET;
        else if (read && wait_reg)
        begin
            case (address)
                OFF_PTR_LOW: rdata_reg <= {24'h00_0000, ptr_reg[7:0]};
                OFF_PTR_HIGH: rdata_reg <= {24'h00_0000, ptr_reg[15:8]};
                OFF_PTR_UPPER: rdata_reg <= {26'h000_0000, ptr_reg[21:16]};
                OFF_LATCH: rdata_reg <= {24'h00_0000, latch_reg};
                OFF_CTRL: rdata_reg <= {24'h00_0000, ctrl_view};
                OFF_IRQ_STATUS: rdata_reg <= {29'h0000_0000, status_reg};
                OFF_IRQ_MASK: rdata_reg <= {29'h0000_0000, mask_reg};
                default: rdata_reg <= RDATA_RESET;
            endcase
        end
    end

    // table pointer, 22 bits over three bytes
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ptr_reg <= {PTR_BYTE_RESET[5:0], PTR_BYTE_RESET, PTR_BYTE_RESET};
        else if (wr_acc)
        begin
            case (address)
                OFF_PTR_LOW: ptr_reg[7:0] <= wb;
                OFF_PTR_HIGH: ptr_reg[15:8] <= wb;
                OFF_PTR_UPPER: ptr_reg[PTR_TOP:16] <= wb[5:0];
                default: ptr_reg <= ptr_reg;
            endcase
        end
    end

    // table latch; a completed read wins over a software write
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            latch_reg <= LATCH_RESET;
        else if (fetch_reg)
            latch_reg <= nv_rdata;
        else if (wr_acc && (address == OFF_LATCH))
            latch_reg <= wb;
    end

    // space selects: frozen during a cycle, kept through a fault
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            code_sel_reg <= 1'b0;
            cfg_sel_reg <= 1'b0;
        end
        else if (wr_ctrl && !launch_reg && !dev_reset)
        begin
            code_sel_reg <= wb[BIT_CODE_SEL];
            cfg_sel_reg <= wb[BIT_CFG_SEL];
        end
    end

    // row erase select and write permit
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            erase_sel_reg <= 1'b0;
            permit_reg <= 1'b0;
        end
        else if (dev_reset)
        begin
            erase_sel_reg <= 1'b0;
            permit_reg <= 1'b0;
        end
        else
        begin
            if (tmr_done && (req_reg.op == NVM_OP_ERASE))
                erase_sel_reg <= 1'b0;
            else if (wr_ctrl && !launch_reg)
                erase_sel_reg <= wb[BIT_ERASE_SEL];
            if (wr_ctrl)
                permit_reg <= wb[BIT_PERMIT];
        end
    end

    // fault flag: hardware set wins over a software clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            fault_reg <= 1'b0;
        else if (aborted || improper)
            fault_reg <= 1'b1;
        else if (wr_ctrl)
            fault_reg <= wb[BIT_FAULT];
    end

    // launch and fetch are set-only; hardware ends them
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            launch_reg <= 1'b0;
            fetch_reg <= 1'b0;
        end
        else if (dev_reset)
        begin
            launch_reg <= 1'b0;
            fetch_reg <= 1'b0;
        end
        else
        begin
            if (start)
                launch_reg <= 1'b1;
            else if (tmr_done)
                launch_reg <= 1'b0;
            fetch_reg <= fetch_req;
        end
    end

    // request toward storage; write/erase held for the whole cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            req_reg <= '0;
        else if (dev_reset)
            req_reg.valid <= 1'b0;
        else if (start)
        begin
            req_reg.valid <= 1'b1;
            req_reg.op <= launch_erase ? NVM_OP_ERASE
                                       : NVM_OP_WRITE;
            req_reg.space <= launch_space;
            req_reg.addr <= launch_addr;
            req_reg.data <= latch_reg;
        end
        else if (fetch_req)
        begin
            req_reg.valid <= 1'b1;
            req_reg.op <= NVM_OP_READ;
            req_reg.space <= NVM_SP_EEPROM;
            req_reg.addr <= ptr_reg;
        end
        else if (fetch_reg || tmr_done || !tmr_busy)
            req_reg.valid <= 1'b0;
    end

    // sticky events, write one to clear, set beats clear
    always_comb
    begin
        status_next = status_reg;
        if (wr_acc && (address == OFF_IRQ_STATUS))
            status_next = status_reg & ~wb[IRQ_W-1:0];
        status_next[IRQ_DONE] = status_next[IRQ_DONE] | tmr_done;
        status_next[IRQ_FAULT] = status_next[IRQ_FAULT] | aborted | improper;
        status_next[IRQ_READ] = status_next[IRQ_READ] | fetch_reg;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            status_reg <= IRQ_RESET;
            mask_reg <= IRQ_RESET;
            irq_reg <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            if (wr_acc && (address == OFF_IRQ_MASK))
                mask_reg <= wb[IRQ_W-1:0];
            // registered so the pin never glitches on a decode
            irq_reg <= |(status_reg & mask_reg);
        end
    end

endmodule

// ### hdl/nvm_cycle_timer.sv
// nvm_cycle_timer: counts out one self-timed write or erase cycle.
// assumes start and abort are single-cycle pulses from the controller.
module nvm_cycle_timer
    import nvm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    output logic busy,
    output logic done
);
    logic [TMR_W-1:0] count_reg;
    localparam logic [TMR_W-1:0] LAST = TMR_W'(PROG_CYCLES - 1);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (abort)
            begin
                busy <= 1'b0;
                count_reg <= '0;
            end
            else if (start)
            begin
                busy <= 1'b1;
                count_reg <= '0;
            end
            else if (busy)
            begin
                if (count_reg == LAST)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                count_reg <= count_reg + 1'b1;
            end
        end
    end

endmodule

// ### hdl/nvm_pkg.sv
// nvm_pkg: constants and types shared by the nonvolatile access control.
// assumes a single 125 MHz core clock and a 32-bit Avalon-MM register bus.
package nvm_pkg;

    // clock and self-timed cycle length
    localparam int unsigned CLK_PERIOD_NS = 8;
    // nominal write/erase time, plain default
    localparam int unsigned PROG_TIME_NS = 2000;
    // least time, rounded up to whole cycles
    localparam int unsigned PROG_CYCLES =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W = 16;

    // register byte offsets
    localparam logic [4:0] OFF_PTR_LOW = 5'h00;
    localparam logic [4:0] OFF_PTR_HIGH = 5'h04;
    localparam logic [4:0] OFF_PTR_UPPER = 5'h08;
    localparam logic [4:0] OFF_LATCH = 5'h0c;
    localparam logic [4:0] OFF_CTRL = 5'h10;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h14;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h18;

    // control register bit positions
    localparam int unsigned BIT_CODE_SEL = 7;
    localparam int unsigned BIT_CFG_SEL = 6;
    localparam int unsigned BIT_UNUSED = 5;
    localparam int unsigned BIT_ERASE_SEL = 4;
    localparam int unsigned BIT_FAULT = 3;
    localparam int unsigned BIT_PERMIT = 2;
    localparam int unsigned BIT_LAUNCH = 1;
    localparam int unsigned BIT_FETCH = 0;

    // pointer geometry
    localparam int unsigned PTR_W = 22;
    localparam int unsigned PTR_TOP = 21;
    localparam int unsigned WRITE_BLK_LSB = 3;
    localparam int unsigned ERASE_BLK_LSB = 6;

    // interrupt status/mask bit positions
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_DONE = 0;
    localparam int unsigned IRQ_FAULT = 1;
    localparam int unsigned IRQ_READ = 2;

    // values after reset
    localparam logic [7:0] PTR_BYTE_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        NVM_OP_READ,
        NVM_OP_WRITE,
        NVM_OP_ERASE
    } nvm_op_t;

    typedef enum logic [1:0]
    {
        NVM_SP_EEPROM,
        NVM_SP_FLASH,
        NVM_SP_CONFIG
    } nvm_space_t;

    // request toward the storage arrays
    typedef struct packed
    {
        logic valid;
        nvm_op_t op;
        nvm_space_t space;
        logic [PTR_W-1:0] addr;
        logic [7:0] data;
    } nvm_req_t;

endpackage
